// ===== wdt_pkg.sv
package wdt_pkg;

    // ------------------------------------------------------------
    // Register map (mapped area only)
    // ------------------------------------------------------------
    localparam logic [7:0] CON_ADDR       = 8'hbb;
    localparam logic [7:0] REL_ADDR       = 8'hbc;
    localparam logic [7:0] WINB_ADDR      = 8'hbd;
    localparam logic [7:0] CNTL_ADDR      = 8'hbe;
    localparam logic [7:0] CNTH_ADDR      = 8'hbf;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int         CON_SVC_BIT    = 0;
    localparam int         CON_RATE_BIT   = 1;
    localparam int         CON_EN_BIT     = 2;
    localparam int         CON_PREW_BIT   = 4;
    localparam int         CON_WINEN_BIT  = 5;
    localparam logic [7:0] RESET_VAL      = 8'h00;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam int         DIV_FAST       = 2;
    localparam int         DIV_SLOW       = 128;
    localparam logic [7:0] PRESC_FAST_TOP = 8'(DIV_FAST - 1);
    localparam logic [7:0] PRESC_SLOW_TOP = 8'(DIV_SLOW - 1);
    localparam int         PREWARN_CYC    = 8;

    // Software register access carrier
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // Watchdog state machine
    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_WARN = 3'b010,
        ST_RST  = 3'b100
    } wdt_state_t;

endpackage

// ===== wdt_prescaler.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Rate prescaler: one pulse every 2 or 128 clocks
// ------------------------------------------------------------
module wdt_prescaler (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    // Control
    input  wire logic run_i,
    input  wire logic slow_i,
    input  wire logic clr_i,
    // Tick
    output logic      tick_o
);
    logic [7:0] cnt_q;  // Divider count
    logic [7:0] top;    // Terminal count

    // Pick the divide ratio
    assign top    = slow_i ? wdt_pkg::PRESC_SLOW_TOP : wdt_pkg::PRESC_FAST_TOP;
    assign tick_o = run_i && (cnt_q >= top);

    // Divider; cleared on service so each period starts aligned
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
        end else if (clr_i || !run_i) begin
            cnt_q <= 8'h00;
        end else if (cnt_q >= top) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

// ===== windowed_watchdog_timer.sv
`timescale 1ns/1ps
module windowed_watchdog_timer #(
    parameter int PREWARN_CYCLES = wdt_pkg::PREWARN_CYC
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // Register access from the CPU
    input  wire wdt_pkg::sfr_req_t sfr_i,
    input  wire logic              sfr_map_select_i,
    input  wire logic              prot_open_i,
    output logic [7:0]             rdata_o,
    output logic                   rvalid_o,
    // Debug
    input  wire logic              debug_mode_i,
    input  wire logic              debug_run_i,
    // Events
    output logic                   nmi_o,
    output logic                   prewarn_o,
    output logic                   sys_reset_o
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (PREWARN_CYCLES < 1 || PREWARN_CYCLES > 255) begin : g_bad_param
        $error("PREWARN_CYCLES out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]          cnt_lo_q;           // Lower counter byte
    logic [7:0]          cnt_hi_q;           // Upper counter byte
    logic [7:0]          reload_value_field_q;   // Reload for upper byte
    logic [7:0]          window_boundary_field_q; // Window boundary
    logic                watchdog_enable_bit_q;  // Counting enable
    logic                rate_slow_q;        // 0: /2, 1: /128
    logic                window_check_enable_q;  // Window check on
    logic [7:0]          warn_cnt_q;         // Prewarning length
    wdt_pkg::wdt_state_t state_q;
    logic                mapped_wr;          // Write to mapped area
    logic                mapped_rd;          // Read of mapped area
    logic                svc;                // Service access
    logic                run;                // Counter advancing
    logic                tick;               // Rate tick
    logic                lo_carry;           // Low byte wraps
    logic                overflow;           // Whole count wraps
    logic                early;              // Service before window
    logic                fail;               // Time-out or window fault

    // Register accesses only hit this block in the mapped area
    assign mapped_wr = sfr_i.wr && sfr_map_select_i;
    assign mapped_rd = sfr_i.rd && sfr_map_select_i;
    assign svc       = mapped_wr && (sfr_i.addr == wdt_pkg::CON_ADDR)
                       && sfr_i.wdata[wdt_pkg::CON_SVC_BIT];
    // Suspended in debug unless the debugger asks it to run
    assign run       = watchdog_enable_bit_q && (state_q == wdt_pkg::ST_RUN)
                       && !(debug_mode_i && !debug_run_i);

    // ------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------
    wdt_prescaler u_presc (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .run_i   (run),
        .slow_i  (rate_slow_q),
        .clr_i   (svc),
        .tick_o  (tick)
    );

    assign lo_carry = tick && (cnt_lo_q == 8'hff);
    assign overflow = lo_carry && (cnt_hi_q == 8'hff);
    // Window fault compares the upper byte against the boundary
    assign early    = svc && window_check_enable_q && watchdog_enable_bit_q
                      && (cnt_hi_q < window_boundary_field_q);
    assign fail     = (state_q == wdt_pkg::ST_RUN) && ((overflow && !svc) || early);

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            watchdog_enable_bit_q   <= 1'b0;
            rate_slow_q             <= 1'b0;
            window_check_enable_q   <= 1'b0;
            reload_value_field_q    <= wdt_pkg::RESET_VAL;
            window_boundary_field_q <= wdt_pkg::RESET_VAL;
        end else if (mapped_wr) begin
            case (sfr_i.addr)
                wdt_pkg::CON_ADDR: begin
                    rate_slow_q           <= sfr_i.wdata[wdt_pkg::CON_RATE_BIT];
                    window_check_enable_q <= sfr_i.wdata[wdt_pkg::CON_WINEN_BIT];
                    // Enable is protected; a closed write leaves it alone
                    if (prot_open_i) begin
                        watchdog_enable_bit_q <= sfr_i.wdata[wdt_pkg::CON_EN_BIT];
                    end
                end
                wdt_pkg::REL_ADDR:  reload_value_field_q    <= sfr_i.wdata;
                wdt_pkg::WINB_ADDR: window_boundary_field_q <= sfr_i.wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Counter bytes
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_lo_q <= 8'h00;
            cnt_hi_q <= 8'h00;
        end else if (svc) begin
            cnt_hi_q <= reload_value_field_q;
            cnt_lo_q <= 8'h00;
        end else if (tick) begin
            cnt_lo_q <= cnt_lo_q + 8'h01;
            if (lo_carry) begin
                cnt_hi_q <= cnt_hi_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Time-out sequence: prewarning with NMI, then system reset
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= wdt_pkg::ST_RUN;
            warn_cnt_q <= 8'h00;
        end else begin
            case (state_q)
                wdt_pkg::ST_RUN: begin
                    if (fail) begin
                        state_q    <= wdt_pkg::ST_WARN;
                        warn_cnt_q <= 8'(PREWARN_CYCLES - 1);
                    end
                end
                wdt_pkg::ST_WARN: begin
                    // Service can no longer rescue the part once warned
                    if (warn_cnt_q == 8'h00) begin
                        state_q <= wdt_pkg::ST_RST;
                    end else begin
                        warn_cnt_q <= warn_cnt_q - 8'h01;
                    end
                end
                wdt_pkg::ST_RST: state_q <= wdt_pkg::ST_RST; // Held until system reset
                default:         state_q <= wdt_pkg::ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Event outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nmi_o       <= 1'b0;
            prewarn_o   <= 1'b0;
            sys_reset_o <= 1'b0;
        end else begin
            nmi_o       <= fail;
            // Prewarning rises with the NMI and drops as the reset rises
            prewarn_o   <= fail
                           || ((state_q == wdt_pkg::ST_WARN) && (warn_cnt_q != 8'h00));
            sys_reset_o <= ((state_q == wdt_pkg::ST_WARN) && (warn_cnt_q == 8'h00))
                           || (state_q == wdt_pkg::ST_RST);
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the read strobe
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= mapped_rd;
            if (mapped_rd) begin
                case (sfr_i.addr)
                    wdt_pkg::CON_ADDR: begin
                        rdata_o <= 8'h00;
                        rdata_o[wdt_pkg::CON_RATE_BIT]  <= rate_slow_q;
                        rdata_o[wdt_pkg::CON_EN_BIT]    <= watchdog_enable_bit_q;
                        rdata_o[wdt_pkg::CON_PREW_BIT]  <= (state_q != wdt_pkg::ST_RUN);
                        rdata_o[wdt_pkg::CON_WINEN_BIT] <= window_check_enable_q;
                    end
                    wdt_pkg::REL_ADDR:  rdata_o <= reload_value_field_q;
                    wdt_pkg::WINB_ADDR: rdata_o <= window_boundary_field_q;
                    wdt_pkg::CNTL_ADDR: rdata_o <= cnt_lo_q;
                    wdt_pkg::CNTH_ADDR: rdata_o <= cnt_hi_q;
                    default:            rdata_o <= 8'h00;
                endcase
            end
        end
    end
endmodule

// ===== windowed_watchdog_timer_bench.sv
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
    // ----------------------------------------
    // Stimulus and observation
    // ----------------------------------------
    logic              mclk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    wdt_pkg::sfr_req_t sfr_i = '0;
    logic              sfr_map_select_i = 1'b1;
    logic              prot_open_i = 1'b1;
    logic              debug_mode_i = 1'b0;
    logic              debug_run_i = 1'b0;
    logic [7:0]        rdata_o, rd_q, v;
    logic              rvalid_o, rv_q, nmi_o, prewarn_o, sys_reset_o;
    int                failures = 0, checks_done = 0, cyc = 0, i;
    always #10 mclk_i = ~mclk_i;
    windowed_watchdog_timer #(.PREWARN_CYCLES(4)) i_dut (.mclk_i, .rst_n_i, .sfr_i,
        .sfr_map_select_i, .prot_open_i, .rdata_o, .rvalid_o, .debug_mode_i,
        .debug_run_i, .nmi_o, .prewarn_o, .sys_reset_o);
    // Cut a hang short; the whole run needs about 1650 cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 10000) begin
            failures++;
            finish_test;
        end
    end
    task chk(input logic ok);
        checks_done++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD %0t value mismatch", $time);
        end
    endtask
    // One access: strobe held for one edge, answer taken after it
    task acc(input logic w, r, input logic [7:0] a, d);
        @(posedge mclk_i) #1;
        sfr_i = '{w, r, a, d};
        @(posedge mclk_i) #1;
        sfr_i = '0;
        rd_q = rdata_o;
        rv_q = rvalid_o;
    endtask
    // Wait n edges, then step clear of the edge so outputs have settled
    task wt(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task rst;
        @(posedge mclk_i) #1;
        rst_n_i = 1'b0;
        wt(4);
        rst_n_i = 1'b1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        rst;
        for (int a = 8'hbb; a <= 8'hc0; a++) begin
            acc(0, 1, 8'(a), 8'h00);
            chk(rv_q === 1'b1 && rd_q === 8'h00);
        end
        sfr_map_select_i = 1'b0;
        acc(1, 0, wdt_pkg::REL_ADDR, 8'h5a);
        acc(0, 1, wdt_pkg::REL_ADDR, 8'h00);
        chk(rv_q === 1'b0);
        sfr_map_select_i = 1'b1;
        acc(0, 1, wdt_pkg::REL_ADDR, 8'h00);
        chk(rd_q === 8'h00);
        prot_open_i = 1'b0;
        acc(1, 0, wdt_pkg::CON_ADDR, 8'h05);
        acc(0, 1, wdt_pkg::CON_ADDR, 8'h00);
        chk(rd_q[2] === 1'b0);
        $display("t_regs done");
    endtask
    task t_count;
        rst;
        acc(1, 0, wdt_pkg::REL_ADDR, 8'h10);
        acc(1, 0, wdt_pkg::CON_ADDR, 8'h05);
        acc(0, 1, wdt_pkg::CNTH_ADDR, 8'h00);
        chk(rd_q === 8'h10);
        wt(600);
        acc(0, 1, wdt_pkg::CNTH_ADDR, 8'h00);
        chk(rd_q === 8'h11);
        acc(1, 0, wdt_pkg::CON_ADDR, 8'h05);
        acc(0, 1, wdt_pkg::CNTL_ADDR, 8'h00);
        chk(rd_q < 8'h04);
        debug_mode_i = 1'b1;
        // A tick may land before suspension takes hold, so sample once suspended
        acc(0, 1, wdt_pkg::CNTL_ADDR, 8'h00);
        v = rd_q;
        wt(60);
        acc(0, 1, wdt_pkg::CNTL_ADDR, 8'h00);
        chk(rd_q === v);
        debug_run_i = 1'b1;
        wt(60);
        acc(0, 1, wdt_pkg::CNTL_ADDR, 8'h00);
        chk(rd_q > v + 8'h10);
        debug_mode_i = 1'b0;
        debug_run_i = 1'b0;
        acc(1, 0, wdt_pkg::CON_ADDR, 8'h07);
        wt(300);
        acc(0, 1, wdt_pkg::CNTL_ADDR, 8'h00);
        chk(rd_q >= 8'h01 && rd_q <= 8'h03);
        chk(nmi_o === 1'b0 && sys_reset_o === 1'b0);
        $display("t_count done");
    endtask
    task t_timeout;
        rst;
        acc(1, 0, wdt_pkg::REL_ADDR, 8'hff);
        acc(1, 0, wdt_pkg::CON_ADDR, 8'h05);
        wt(480);
        chk(nmi_o === 1'b0 && prewarn_o === 1'b0);
        i = 0;
        while (nmi_o !== 1'b1 && i < 100) begin
            wt(1);
            i++;
        end
        chk(i > 0 && i < 60);
        acc(0, 1, wdt_pkg::CON_ADDR, 8'h00);
        chk(rd_q[4] === 1'b1);
        wt(10);
        chk(sys_reset_o === 1'b1 && prewarn_o === 1'b0);
        $display("t_timeout done");
    endtask
    task t_window;
        rst;
        acc(1, 0, wdt_pkg::WINB_ADDR, 8'h80);
        acc(1, 0, wdt_pkg::REL_ADDR, 8'h90);
        acc(1, 0, wdt_pkg::CON_ADDR, 8'h05);
        acc(1, 0, wdt_pkg::CON_ADDR, 8'h25);
        wt(10);
        chk(prewarn_o === 1'b0 && sys_reset_o === 1'b0);
        acc(1, 0, wdt_pkg::REL_ADDR, 8'h10);
        acc(1, 0, wdt_pkg::CON_ADDR, 8'h25);
        acc(1, 0, wdt_pkg::CON_ADDR, 8'h25);
        wt(2);
        chk(prewarn_o === 1'b1);
        wt(10);
        chk(sys_reset_o === 1'b1);
        $display("t_window done");
    endtask
    task finish_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        t_regs;
        prot_open_i = 1'b1;
        t_count;
        t_timeout;
        t_window;
        finish_test;
    end
endmodule
bind windowed_watchdog_timer windowed_watchdog_timer_props #(
    .PREWARN_CYCLES(PREWARN_CYCLES)
) i_props (.mclk_i, .rst_n_i, .sfr_i, .sfr_map_select_i, .prot_open_i, .rdata_o,
    .rvalid_o, .debug_mode_i, .debug_run_i, .nmi_o, .prewarn_o, .sys_reset_o);

// ===== windowed_watchdog_timer_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the watchdog
// ----------------------------------------
module windowed_watchdog_timer_props #(
    parameter int PREWARN_CYCLES = 8
) (
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // Register access
    input  wire wdt_pkg::sfr_req_t sfr_i,
    input  wire logic              sfr_map_select_i,
    input  wire logic              prot_open_i,
    input  wire logic [7:0]        rdata_o,
    input  wire logic              rvalid_o,
    // Debug and events
    input  wire logic              debug_mode_i,
    input  wire logic              debug_run_i,
    input  wire logic              nmi_o,
    input  wire logic              prewarn_o,
    input  wire logic              sys_reset_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    logic rd_s;   // Read taken by the block
    int   warn_q; // Prewarning cycles seen so far
    assign rd_s = sfr_i.rd && sfr_map_select_i;
    // Length of the prewarning level
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) warn_q <= 0;
        else          warn_q <= prewarn_o ? warn_q + 1 : 0;
    end
    AST_READ_ACK: assert property (rd_s |=> rvalid_o)
        else $error("read not answered");
    AST_READ_ONLY: assert property (!rd_s |=> !rvalid_o)
        else $error("answer without read");
    AST_UNMAPPED: assert property (rd_s && (sfr_i.addr < wdt_pkg::CON_ADDR
        || sfr_i.addr > wdt_pkg::CNTH_ADDR) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_SVC_RD0: assert property (rd_s && sfr_i.addr == wdt_pkg::CON_ADDR
        |=> !rdata_o[wdt_pkg::CON_SVC_BIT]) else $error("service bit reads one");
    AST_RDATA_HOLD: assert property (!rvalid_o |-> $stable(rdata_o))
        else $error("read data moved");
    AST_NMI_PULSE: assert property (nmi_o |=> !nmi_o) else $error("nmi too long");
    AST_NMI_WARN: assert property (nmi_o |-> prewarn_o && warn_q == 0)
        else $error("nmi without prewarning start");
    AST_WARN_LEN: assert property ($fell(prewarn_o) |-> warn_q == PREWARN_CYCLES)
        else $error("prewarning length wrong");
    AST_RST_FOLLOW: assert property ($fell(prewarn_o) |-> ##[0:1] sys_reset_o)
        else $error("no reset after prewarning");
    AST_RST_STICKY: assert property (sys_reset_o |=> sys_reset_o)
        else $error("system reset dropped");
    cover property (nmi_o);
    cover property ($fell(prewarn_o));
    cover property (rd_s && sfr_i.addr == wdt_pkg::CNTL_ADDR);
endmodule
